// >>> rtl/osc_pkg.sv
// constants, codes and helper functions for the oscillator source select control
//
// Contract
// - Software clock switching allowed only when switch/monitor config upper bit is zero.
// - Fail-safe clock monitor enabled only when both switch/monitor config bits are zero.
// - Source codes: 111 divided fast RC, 101 low-power RC, 100 secondary, 001/000 fast RC.
// - Code 011 primary with PLL, 010 without; submode 01 std, 10 fast crystal, 00 external.
// - Erased configuration powers up on the divided fast RC source.
// - Read-only current-source field at bits 14..12, same source encoding.
// - Writable new-source field at bits 10..8, reset from initial-source config.
// - Selection lock bit 7 is set-only; with monitor on it freezes selections.
// - Pin map lock bit 6 changes only after unlock; one-way config blocks clearing.
// - PLL lock flag bit 5 shows PLL lock, zero when unlocked or disabled.
// - PLL lock flag cleared on every valid switch and in non-PLL modes.
// - Clock-fail flag set by monitor failure, software clear-only, resets to zero.
// - Primary oscillator runs in sleep only when sleep-enable bit 2 is one.
// - Bit 1 enables the secondary oscillator.
// - Software sets switch request bit 0; hardware clears it when switch completes.
// - Unimplemented bits 15, 11 and 4 read as zero.
// - Oscillator output pin function comes from config bit in internal/secondary modes.
// - Switch request with equal sources aborts; otherwise clears PLL lock and fail flag (code also aborts reserved or PLL-to-PLL targets, clearing neither).
// - Start source, await start-up and lock, ten new-clock cycles, then switch.
package osc_pkg;
  localparam int OSC_ADDR_W = 4;
  localparam logic [OSC_ADDR_W-1:0] OSC_CTRL_OFF = 4'h0;

  localparam int OSC_CUR_LSB = 12;
  localparam int OSC_NEW_LSB = 8;
  localparam int OSC_CLK_LOCK_BIT = 7;
  localparam int OSC_PIN_LOCK_BIT = 6;
  localparam int OSC_PLL_LOCK_BIT = 5;
  localparam int OSC_FAIL_BIT = 3;
  localparam int OSC_PRIM_SLEEP_BIT = 2;
  localparam int OSC_SEC_EN_BIT = 1;
  localparam int OSC_SW_REQ_BIT = 0;

  localparam logic [2:0] OSC_SRC_FAST_RC = 3'h0;
  localparam logic [2:0] OSC_SRC_FAST_RC_PLL = 3'h1;
  localparam logic [2:0] OSC_SRC_PRIMARY = 3'h2;
  localparam logic [2:0] OSC_SRC_PRIMARY_PLL = 3'h3;
  localparam logic [2:0] OSC_SRC_SECONDARY = 3'h4;
  localparam logic [2:0] OSC_SRC_LOW_POWER_RC = 3'h5;
  localparam logic [2:0] OSC_SRC_RESERVED = 3'h6;
  localparam logic [2:0] OSC_SRC_FAST_RC_DIV = 3'h7;

  localparam logic [1:0] OSC_PM_EXT_CLOCK = 2'h0;
  localparam logic [1:0] OSC_PM_STD_XTAL = 2'h1;
  localparam logic [1:0] OSC_PM_FAST_XTAL = 2'h2;
  localparam logic [1:0] OSC_SM_MONITOR_ON = 2'h0;

  localparam logic [7:0] OSC_KEY_HI1 = 8'h78;
  localparam logic [7:0] OSC_KEY_HI2 = 8'h9A;
  localparam logic [7:0] OSC_KEY_LO1 = 8'h46;
  localparam logic [7:0] OSC_KEY_LO2 = 8'h57;

  localparam int OSC_SWITCH_EDGES = 10;
  localparam int OSC_HAND_GAP = 2;

  function automatic logic osc_is_pll(input logic [2:0] s);
    return (s == OSC_SRC_PRIMARY_PLL) || (s == OSC_SRC_FAST_RC_PLL);
  endfunction : osc_is_pll

  function automatic logic osc_uses_primary(input logic [2:0] s);
    return (s == OSC_SRC_PRIMARY) || (s == OSC_SRC_PRIMARY_PLL);
  endfunction : osc_uses_primary

  // pll-to-pll direct moves and the reserved code are not permitted targets
  function automatic logic osc_switch_ok(input logic [2:0] cur, input logic [2:0] nw);
    return (nw != OSC_SRC_RESERVED) &&
           !(cur == OSC_SRC_PRIMARY_PLL && nw == OSC_SRC_FAST_RC_PLL) &&
           !(cur == OSC_SRC_FAST_RC_PLL && nw == OSC_SRC_PRIMARY_PLL);
  endfunction : osc_switch_ok
endpackage : osc_pkg

// >>> rtl/osc_unlock.sv
// two-key unlock detector for one byte lane of the control register
`timescale 1ns/10ps
`default_nettype none
module osc_unlock #(
  parameter logic [7:0] KEY1 = 8'h00,
  parameter logic [7:0] KEY2 = 8'h00
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic lane_wr,
  input wire logic [7:0] lane_data,
  output logic key_write,
  output logic lane_open
);
  typedef enum logic [1:0] {UL_IDLE, UL_ARMED, UL_OPEN} osc_ul_e;
  typedef struct packed {
    osc_ul_e st;
  } osc_ul_s;

  osc_ul_s r, n;

  always_comb begin
    n = r;
    key_write = 1'b0;
    case (r.st)
      UL_IDLE: begin
        if (lane_wr && lane_data == KEY1) begin
          n.st = UL_ARMED;
          key_write = 1'b1;
        end
      end
      UL_ARMED: begin
        if (lane_wr) begin
          key_write = (lane_data == KEY2) || (lane_data == KEY1);
          if (lane_data == KEY2) begin
            n.st = UL_OPEN;
          end else if (lane_data != KEY1) begin
            n.st = UL_IDLE;
          end
        end
      end
      UL_OPEN: begin
        // the very next lane write consumes the unlock, whatever it holds
        if (lane_wr) begin
          n.st = UL_IDLE;
        end
      end
      default: n.st = UL_IDLE;
    endcase
    if (rst) begin
      n.st = UL_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    r <= n;
  end

  assign lane_open = (r.st == UL_OPEN);

  open_once_a: assert property (@(posedge core_clk) disable iff (rst)
    (r.st == UL_OPEN && lane_wr) |=> (r.st == UL_IDLE))
    else $error("unlock survived past its single write");
endmodule : osc_unlock
`default_nettype wire

// >>> rtl/osc_clk_mux.sv
// break-before-make gating of the clock sources
`timescale 1ns/10ps
`default_nettype none
module osc_clk_mux
  import osc_pkg::*;
#(
  parameter int GAP = OSC_HAND_GAP
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [2:0] init_sel,
  input wire logic go,
  input wire logic [2:0] sel,
  output logic [7:0] gate_en,
  output logic done
);
  typedef enum logic {MX_RUN, MX_GAP} osc_mx_e;
  typedef struct packed {
    osc_mx_e st;
    logic [3:0] cnt;
    logic [7:0] gate;
    logic done;
  } osc_mx_s;

  osc_mx_s r, n;

  always_comb begin
    n = r;
    n.done = 1'b0;
    case (r.st)
      MX_RUN: begin
        // old gate drops first so the two never overlap
        if (go) begin
          n.gate = 8'h00;
          n.cnt = 4'h0;
          n.st = MX_GAP;
        end
      end
      MX_GAP: begin
        n.cnt = r.cnt + 4'h1;
        if (r.cnt == 4'(GAP - 1)) begin
          n.gate = 8'(1) << sel;
          n.done = 1'b1;
          n.st = MX_RUN;
        end
      end
      default: n.st = MX_RUN;
    endcase
    if (rst) begin
      n.st = MX_RUN;
      n.cnt = 4'h0;
      n.gate = 8'(1) << init_sel;
      n.done = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    r <= n;
  end

  assign gate_en = r.gate;
  assign done = r.done;

  gate_onehot_a: assert property (@(posedge core_clk) disable iff (rst)
    $onehot0(gate_en))
    else $error("clock gates overlap");

  gate_gap_a: assert property (@(posedge core_clk) disable iff (rst)
    (go && r.st == MX_RUN) |=> (gate_en == 8'h00) [*2])
    else $error("handover gap too short");
endmodule : osc_clk_mux
`default_nettype wire

// >>> rtl/osc_ctrl.sv
// oscillator control register, switch sequencer and source enables
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module osc_ctrl (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [osc_pkg::OSC_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [1:0] reg_be,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [1:0] cfg_switch_monitor,
  input wire logic [1:0] cfg_primary_submode,
  input wire logic [2:0] cfg_initial_source,
  input wire logic cfg_pin_map_lock_one_way,
  input wire logic cfg_osc_out_pin_function,
  input wire logic sleep_mode,
  input wire logic pll_locked_in,
  input wire logic xtal_start_done_in,
  input wire logic new_src_clk_in,
  input wire logic fail_detect_in,
  output logic [7:0] src_gate_en,
  output logic pll_en,
  output logic primary_osc_en,
  output logic secondary_osc_en,
  output logic [1:0] primary_submode,
  output logic osc_out_pin_gpio,
  output logic pin_map_lock,
  output logic clock_fail,
  output logic fail_monitor_en,
  output logic switch_busy
);
  import osc_pkg::*;

  localparam logic [3:0] EDGE_LAST = 4'(OSC_SWITCH_EDGES);

  typedef enum logic [1:0] {SW_IDLE, SW_START, SW_COUNT, SW_HAND} osc_sw_e;
  typedef struct packed {
    osc_sw_e st;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] edge_cnt;
    logic [2:0] cur_src;
    logic [2:0] new_src;
    logic clk_lock;
    logic pin_lock;
    logic pll_lock;
    logic fail;
    logic prim_sleep;
    logic sec_en;
    logic sw_req;
    logic hand_go;
    logic [15:0] rdata;
  } osc_ctrl_s;

  osc_ctrl_s r, n;

  logic hit;
  logic wr_hi;
  logic wr_lo;
  logic hi_key;
  logic hi_open;
  logic lo_key;
  logic lo_open;
  logic mux_done;
  logic sw_allowed;
  logic sel_locked;
  logic pll_s;
  logic xtal_s;
  logic nclk_rise;
  logic fail_rise;
  logic accept;
  logic [15:0] word;

  assign hit = (reg_addr == OSC_CTRL_OFF);
  assign wr_hi = reg_wr && hit && reg_be[1];
  assign wr_lo = reg_wr && hit && reg_be[0];

  osc_unlock #(.KEY1(OSC_KEY_HI1), .KEY2(OSC_KEY_HI2)) u_hi_unlock (
    .core_clk(core_clk),
    .rst(rst),
    .lane_wr(wr_hi),
    .lane_data(reg_wdata[15:8]),
    .key_write(hi_key),
    .lane_open(hi_open)
  );

  osc_unlock #(.KEY1(OSC_KEY_LO1), .KEY2(OSC_KEY_LO2)) u_lo_unlock (
    .core_clk(core_clk),
    .rst(rst),
    .lane_wr(wr_lo),
    .lane_data(reg_wdata[7:0]),
    .key_write(lo_key),
    .lane_open(lo_open)
  );

  osc_clk_mux #(.GAP(OSC_HAND_GAP)) u_mux (
    .core_clk(core_clk),
    .rst(rst),
    .init_sel(cfg_initial_source),
    .go(r.hand_go),
    .sel(r.new_src),
    .gate_en(src_gate_en),
    .done(mux_done)
  );

  assign sw_allowed = !cfg_switch_monitor[1];
  assign fail_monitor_en = (cfg_switch_monitor == OSC_SM_MONITOR_ON);
  assign sel_locked = r.clk_lock && fail_monitor_en;

  // only second stages and their delayed copies are looked at
  assign pll_s = r.s2[0];
  assign xtal_s = r.s2[1];
  assign nclk_rise = r.s2[2] && !r.s3[2];
  assign fail_rise = r.s2[3] && !r.s3[3];

  assign accept = (r.st == SW_IDLE) && r.sw_req && (r.new_src != r.cur_src) &&
                  osc_switch_ok(r.cur_src, r.new_src);

  always_comb begin
    word = 16'h0000;
    word[OSC_CUR_LSB +: 3] = r.cur_src;
    word[OSC_NEW_LSB +: 3] = r.new_src;
    word[OSC_CLK_LOCK_BIT] = r.clk_lock;
    word[OSC_PIN_LOCK_BIT] = r.pin_lock;
    word[OSC_PLL_LOCK_BIT] = r.pll_lock;
    word[OSC_FAIL_BIT] = r.fail;
    word[OSC_PRIM_SLEEP_BIT] = r.prim_sleep;
    word[OSC_SEC_EN_BIT] = r.sec_en;
    word[OSC_SW_REQ_BIT] = r.sw_req;
  end

  always_comb begin
    n = r;
    n.hand_go = 1'b0;
    n.s1 = {fail_detect_in, new_src_clk_in, xtal_start_done_in, pll_locked_in};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.rdata = (reg_rd && hit) ? word : 16'h0000;

    // pll lock follows the source in use, or the target while switching
    if (r.st == SW_IDLE) begin
      n.pll_lock = osc_is_pll(r.cur_src) && pll_s;
    end else begin
      n.pll_lock = osc_is_pll(r.new_src) && pll_s;
    end

    // new source only in the write right after the high keys
    if (wr_hi && hi_open && !sel_locked && sw_allowed && r.st == SW_IDLE) begin
      n.new_src = reg_wdata[OSC_NEW_LSB +: 3];
    end

    // key writes never touch the ordinary low bits
    if (wr_lo && !lo_key) begin
      n.prim_sleep = reg_wdata[OSC_PRIM_SLEEP_BIT];
      n.sec_en = reg_wdata[OSC_SEC_EN_BIT];
      if (reg_wdata[OSC_CLK_LOCK_BIT]) begin
        n.clk_lock = 1'b1;
      end
      if (!reg_wdata[OSC_FAIL_BIT]) begin
        n.fail = 1'b0;
      end
      if (lo_open) begin
        if (!(cfg_pin_map_lock_one_way && r.pin_lock)) begin
          n.pin_lock = reg_wdata[OSC_PIN_LOCK_BIT];
        end
        if (reg_wdata[OSC_SW_REQ_BIT] && !sel_locked && r.st == SW_IDLE) begin
          n.sw_req = 1'b1;
        end
      end
    end

    case (r.st)
      SW_IDLE: begin
        if (accept) begin
          n.pll_lock = 1'b0;
          n.fail = 1'b0;
          n.edge_cnt = 4'h0;
          n.st = SW_START;
        end else if (r.sw_req) begin
          n.sw_req = 1'b0;
        end
      end
      SW_START: begin
        // external clock needs no start-up timer, crystals do
        if ((!osc_uses_primary(r.new_src) || cfg_primary_submode == OSC_PM_EXT_CLOCK ||
             xtal_s) && (!osc_is_pll(r.new_src) || pll_s)) begin
          n.st = SW_COUNT;
        end
      end
      SW_COUNT: begin
        if (nclk_rise) begin
          n.edge_cnt = r.edge_cnt + 4'h1;
          if (r.edge_cnt == EDGE_LAST - 4'h1) begin
            n.hand_go = 1'b1;
            n.st = SW_HAND;
          end
        end
      end
      SW_HAND: begin
        if (mux_done) begin
          n.cur_src = r.new_src;
          n.sw_req = 1'b0;
          n.st = SW_IDLE;
        end
      end
      default: n.st = SW_IDLE;
    endcase

    if (!sw_allowed) begin
      n.sw_req = 1'b0;
    end
    // a failure in the same cycle as a clear still sticks
    if (fail_monitor_en && fail_rise) begin
      n.fail = 1'b1;
    end

    if (rst) begin
      n = '0;
      n.st = SW_IDLE;
      // erased config reads all ones, which is the divided fast RC code
      n.cur_src = cfg_initial_source;
      n.new_src = cfg_initial_source;
    end
  end

  always_ff @(posedge core_clk) begin
    r <= n;
  end

  assign reg_rdata = r.rdata;
  assign switch_busy = (r.st != SW_IDLE);
  assign pll_en = osc_is_pll(r.cur_src) || (switch_busy && osc_is_pll(r.new_src));
  assign primary_submode = cfg_primary_submode;
  assign primary_osc_en = (osc_uses_primary(r.cur_src) ||
                           (switch_busy && osc_uses_primary(r.new_src))) &&
                          (!sleep_mode || r.prim_sleep);
  assign secondary_osc_en = r.sec_en || (r.cur_src == OSC_SRC_SECONDARY) ||
                            (switch_busy && r.new_src == OSC_SRC_SECONDARY);
  // pin belongs to the crystal in primary modes
  assign osc_out_pin_gpio = osc_uses_primary(r.cur_src) ? 1'b0 : cfg_osc_out_pin_function;
  assign pin_map_lock = r.pin_lock;
  assign clock_fail = r.fail;

  sw_disabled_a: assert property (@(posedge core_clk) disable iff (rst)
    !sw_allowed |=> !r.sw_req && r.cur_src == $past(r.cur_src))
    else $error("switch request held while switching disabled");

  monitor_off_a: assert property (@(posedge core_clk) disable iff (rst)
    (!fail_monitor_en && !r.fail) |=> !r.fail)
    else $error("fail flag set with monitor disabled");

  reset_source_a: assert property (@(posedge core_clk)
    rst |=> (r.new_src == $past(cfg_initial_source)) && (r.cur_src == $past(cfg_initial_source)))
    else $error("source fields not loaded from config at reset");

  valid_switch_a: assert property (@(posedge core_clk) disable iff (rst)
    accept |=> (r.st == SW_START) && !r.pll_lock && r.sw_req)
    else $error("valid switch did not clear lock or start");

  redundant_abort_a: assert property (@(posedge core_clk) disable iff (rst)
    (r.st == SW_IDLE && r.sw_req && r.new_src == r.cur_src && !wr_lo) |=>
    !r.sw_req && r.st == SW_IDLE)
    else $error("redundant switch not aborted");

  fail_sticky_a: assert property (@(posedge core_clk) disable iff (rst)
    (fail_monitor_en && fail_rise) |=> r.fail)
    else $error("clock failure lost");

  clk_lock_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    r.clk_lock |=> r.clk_lock)
    else $error("selection lock cleared");

  one_way_a: assert property (@(posedge core_clk) disable iff (rst)
    (cfg_pin_map_lock_one_way && r.pin_lock) |=> r.pin_lock)
    else $error("one-way pin map lock cleared");

  rsvd_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(reg_rd && hit) |-> (reg_rdata & 16'h8810) == 16'h0000 && reg_rdata[14:12] == $past(r.cur_src))
    else $error("reserved bits or current source misread");

  ten_edges_a: assert property (@(posedge core_clk) disable iff (rst)
    (r.st == SW_HAND) |-> (r.edge_cnt == EDGE_LAST))
    else $error("handover before ten new-clock edges");

  cur_update_a: assert property (@(posedge core_clk) disable iff (rst)
    (r.cur_src != $past(r.cur_src)) |-> $past(r.st == SW_HAND && mux_done) && !r.sw_req)
    else $error("current source changed outside handover");

  sleep_stop_a: assert property (@(posedge core_clk) disable iff (rst)
    (sleep_mode && !r.prim_sleep) |-> !primary_osc_en)
    else $error("primary oscillator running in sleep");

  // a key write on the high lane is never itself the protected write
  hi_key_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
    hi_key |=> r.new_src == $past(r.new_src))
    else $error("high key write changed the new source");
endmodule : osc_ctrl
`default_nettype wire

// >>> dv/osc_ctrl_test.sv
// self-checking bench for the oscillator control register and switch sequencer
`timescale 1ns/10ps
`default_nettype none
module osc_ctrl_test;
  import osc_pkg::*;
  localparam logic [2:0] SW_TBL [12] = '{3'h0, 3'h1, 3'h0, 3'h2, 3'h3, 3'h1,
                                         3'h0, 3'h4, 3'h5, 3'h5, 3'h6, 3'h7};
  logic core_clk, rst, reg_wr, reg_rd, sleep_mode, pll_locked_in, xtal_start_done_in;
  logic new_src_clk_in, fail_detect_in, cfg_pin_map_lock_one_way, cfg_osc_out_pin_function;
  logic [OSC_ADDR_W-1:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic [1:0] reg_be, cfg_switch_monitor, cfg_primary_submode, primary_submode;
  logic [2:0] cfg_initial_source, cur_e, new_e;
  logic [7:0] src_gate_en;
  logic pll_en, primary_osc_en, secondary_osc_en, osc_out_pin_gpio, pin_map_lock;
  logic clock_fail, fail_monitor_en, switch_busy;
  logic clk_lk, pinlk, cf, slp_en, sec_en;
  int err_total, check_count, seed;

  osc_ctrl osc_ctrl_inst (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cfg_switch_monitor(cfg_switch_monitor),
    .cfg_primary_submode(cfg_primary_submode), .cfg_initial_source(cfg_initial_source),
    .cfg_pin_map_lock_one_way(cfg_pin_map_lock_one_way),
    .cfg_osc_out_pin_function(cfg_osc_out_pin_function), .sleep_mode(sleep_mode),
    .pll_locked_in(pll_locked_in), .xtal_start_done_in(xtal_start_done_in),
    .new_src_clk_in(new_src_clk_in), .fail_detect_in(fail_detect_in),
    .src_gate_en(src_gate_en), .pll_en(pll_en), .primary_osc_en(primary_osc_en),
    .secondary_osc_en(secondary_osc_en), .primary_submode(primary_submode),
    .osc_out_pin_gpio(osc_out_pin_gpio), .pin_map_lock(pin_map_lock),
    .clock_fail(clock_fail), .fail_monitor_en(fail_monitor_en), .switch_busy(switch_busy));

  always #50 core_clk = ~core_clk;

  // new source runs at a sixth of the core rate, well inside the sync limit
  always begin
    repeat (3) @(posedge core_clk);
    new_src_clk_in <= ~new_src_clk_in;
  end

  function automatic logic is_pll(input logic [2:0] s);
    return s == 3'h1 || s == 3'h3;
  endfunction : is_pll

  function automatic logic is_prim(input logic [2:0] s);
    return s == 3'h2 || s == 3'h3;
  endfunction : is_prim

  function automatic logic [15:0] exp_reg(input logic pll);
    return {1'b0, cur_e, 1'b0, new_e, clk_lk, pinlk, pll, 1'b0, cf, slp_en, sec_en, 1'b0};
  endfunction : exp_reg

  // bit3 written as one so the fail flag is never cleared by accident
  function automatic logic [7:0] lo_w(input logic req);
    return {clk_lk, pinlk, 2'b00, 1'b1, slp_en, sec_en, req};
  endfunction : lo_w

  task automatic stop_test;
    if (err_total == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_reg

  task automatic chk_sig(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_sig

  // strobe stays up so writes can run back to back; idle drops it
  task automatic wr(input logic [3:0] a, input logic [1:0] be, input logic [15:0] d);
    reg_addr <= a;
    reg_be <= be;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
  endtask : wr

  task automatic idle;
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : idle

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_wr <= 1'b0;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask : rd

  task automatic low_wr(input logic unlock, input logic [7:0] lo);
    if (unlock) begin
      wr(OSC_CTRL_OFF, 2'b01, {8'h00, OSC_KEY_LO1});
      wr(OSC_CTRL_OFF, 2'b01, {8'h00, OSC_KEY_LO2});
    end
    wr(OSC_CTRL_OFF, 2'b01, {8'h00, lo});
    idle;
  endtask : low_wr

  task automatic do_reset(input logic [1:0] sm, input logic [2:0] src);
    cfg_switch_monitor <= sm;
    cfg_initial_source <= src;
    cfg_primary_submode <= 2'($random(seed));
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    cur_e = src;
    new_e = src;
    {clk_lk, pinlk, cf, slp_en, sec_en} = 5'h00;
  endtask : do_reset

  task automatic pulse_fail;
    fail_detect_in <= 1'b1;
    repeat (5) @(posedge core_clk);
    fail_detect_in <= 1'b0;
    repeat (5) @(posedge core_clk);
    cf = 1'b1;
  endtask : pulse_fail

  task automatic do_switch(input logic [2:0] t);
    logic ok;
    logic take;
    int n;
    logic [15:0] d;
    slp_en = 1'($random(seed));
    sec_en = 1'($random(seed));
    sleep_mode <= 1'($random(seed));
    take = !cfg_switch_monitor[1] && !(clk_lk && cfg_switch_monitor == OSC_SM_MONITOR_ON);
    wr(OSC_CTRL_OFF, 2'b10, {OSC_KEY_HI1, 8'h00});
    wr(OSC_CTRL_OFF, 2'b10, {OSC_KEY_HI2, 8'h00});
    wr(OSC_CTRL_OFF, 2'b10, {5'h00, t, 8'h00});
    if (take)
      new_e = t;
    ok = take && new_e != cur_e && new_e != OSC_SRC_RESERVED && !(is_pll(cur_e) && is_pll(new_e));
    low_wr(1'b1, lo_w(1'b1));
    @(posedge core_clk);
    #1;
    chk_sig(8'(switch_busy), 8'(ok), "busy after request");
    if (ok)
      cf = 1'b0;
    rd(OSC_CTRL_OFF, d);
    chk_reg(d & 16'hFFDF, exp_reg(1'b0) | 16'(ok), "during switch");
    n = 0;
    #1;
    while (switch_busy !== 1'b0 && n < 400) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk_sig(8'(n < 400), 8'h01, "switch never ends");
    if (ok) begin
      chk_sig(8'(n >= (OSC_SWITCH_EDGES - 1) * 6), 8'h01, "switch too early");
      cur_e = new_e;
    end
    chk_sig(src_gate_en, 8'h01 << cur_e, "source gate");
    chk_sig(8'(pll_en), 8'(is_pll(cur_e)), "pll enable");
    chk_sig(8'(primary_osc_en), 8'(is_prim(cur_e) && (!sleep_mode || slp_en)), "prim en");
    chk_sig(8'(secondary_osc_en), 8'(sec_en || cur_e == 3'h4), "sec en");
    chk_sig(8'(osc_out_pin_gpio), 8'(!is_prim(cur_e) && cfg_osc_out_pin_function), "pin");
    rd(OSC_CTRL_OFF, d);
    chk_reg(d, exp_reg(is_pll(cur_e) && pll_locked_in), "after switch");
  endtask : do_switch

  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    stop_test;
  end

  initial begin
    seed = 32'haec3;
    err_total = 0;
    check_count = 0;
    {core_clk, rst, reg_wr, reg_rd, sleep_mode, new_src_clk_in, fail_detect_in} = 7'h02;
    {reg_addr, reg_wdata, reg_be} = '0;
    {pll_locked_in, xtal_start_done_in, cfg_pin_map_lock_one_way} = 3'h7;
    cfg_osc_out_pin_function = 1'($random(seed));
    cfg_switch_monitor = 2'h0;
    cfg_primary_submode = 2'h0;
    cfg_initial_source = 3'h7;
    do_reset(OSC_SM_MONITOR_ON, OSC_SRC_FAST_RC_DIV);
    rd(OSC_CTRL_OFF, v);
    chk_reg(v, exp_reg(1'b0), "reset value");
    chk_sig(src_gate_en, 8'h80, "reset gate");
    chk_sig(8'(fail_monitor_en), 8'h01, "monitor on");
    rd(4'h3, v);
    chk_reg(v, 16'h0000, "unmapped read");
    wr(4'h3, 2'b11, 16'h0206);
    wr(OSC_CTRL_OFF, 2'b11, 16'hFF7F);
    idle;
    slp_en = 1'b1;
    sec_en = 1'b1;
    rd(OSC_CTRL_OFF, v);
    chk_reg(v, exp_reg(1'b0), "plain write");
    chk_sig(8'(secondary_osc_en), 8'h01, "sec bit");
    pulse_fail;
    chk_sig(8'(clock_fail), 8'h01, "fail set");
    low_wr(1'b0, lo_w(1'b0));
    rd(OSC_CTRL_OFF, v);
    chk_reg(v, exp_reg(1'b0), "fail write one");
    low_wr(1'b0, lo_w(1'b0) & 8'hF7);
    cf = 1'b0;
    rd(OSC_CTRL_OFF, v);
    chk_reg(v, exp_reg(1'b0), "fail clear");
    pulse_fail;
    for (int i = 0; i < 12; i++)
      do_switch(SW_TBL[i]);
    repeat (6)
      do_switch(3'($random(seed)));
    low_wr(1'b0, lo_w(1'b0) | 8'h40);
    chk_sig(8'(pin_map_lock), 8'h00, "pin lock no key");
    pinlk = 1'b1;
    low_wr(1'b1, lo_w(1'b0));
    chk_sig(8'(pin_map_lock), 8'h01, "pin lock set");
    low_wr(1'b1, lo_w(1'b0) & 8'hBF);
    chk_sig(8'(pin_map_lock), 8'h01, "pin lock one way");
    clk_lk = 1'b1;
    low_wr(1'b0, lo_w(1'b0));
    low_wr(1'b0, lo_w(1'b0) & 8'h7F);
    rd(OSC_CTRL_OFF, v);
    chk_reg(v, exp_reg(is_pll(cur_e)), "lock set only");
    do_switch(cur_e == 3'h0 ? 3'h5 : 3'h0);
    do_reset(2'b10, OSC_SRC_PRIMARY);
    chk_sig(8'(fail_monitor_en), 8'h00, "monitor off");
    chk_sig(8'(primary_submode), 8'(cfg_primary_submode), "submode");
    pulse_fail;
    cf = 1'b0;
    chk_sig(8'(clock_fail), 8'h00, "fail with monitor off");
    do_switch(OSC_SRC_FAST_RC);
    stop_test;
  end
endmodule : osc_ctrl_test
`default_nettype wire
